// ---- common/devctl_pkg.sv ----
// constants shared by the port device control block
package devctl_pkg;

	// register bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// register byte addresses
	localparam logic [7:0] DEV_CAP_ADDR = 8'hC4;
	localparam logic [7:0] DEV_CTL_ADDR = 8'hC8;

	// device control field positions
	localparam int unsigned CE_EN_BIT  = 0;
	localparam int unsigned NFE_EN_BIT = 1;
	localparam int unsigned FE_EN_BIT  = 2;
	localparam int unsigned UR_EN_BIT  = 3;
	localparam int unsigned RLX_BIT    = 4;
	localparam int unsigned MPS_LSB    = 5;
	localparam int unsigned ETAG_BIT   = 8;
	localparam int unsigned PHF_BIT    = 9;
	localparam int unsigned AUX_EN_BIT = 10;
	localparam int unsigned SNOOP_BIT  = 11;
	localparam int unsigned MRRS_LSB   = 12;
	localparam int unsigned RSVD_BIT   = 15;

	// device status field positions, upper half of the control word
	localparam int unsigned STS_LSB     = 16;
	localparam int unsigned AUX_DET_BIT = 20;
	localparam int unsigned TPEND_BIT   = 21;

	// device capabilities field positions
	localparam int unsigned CAP_MPS_LSB  = 0;
	localparam int unsigned CAP_RBER_BIT = 15;

	// values after reset and hardwired values
	localparam logic [3:0] ERR_EN_RST    = 4'h0;
	localparam logic [2:0] MPS_RST       = 3'h0;
	localparam logic       AUX_EN_RST    = 1'h0;
	localparam logic [2:0] MPS_SUP_SMALL = 3'h1;
	localparam logic [2:0] MPS_SUP_LARGE = 3'h2;
	localparam logic [2:0] MRRS_VAL      = 3'h0;
	localparam logic       RBER_VAL      = 1'h1;
	localparam logic [3:0] STS_RST       = 4'h0;

endpackage

// ---- tb/switch_port_device_control_tb_top.sv ----
// self-checking bench for the port device control register bank
`timescale 1ns/1ns
`default_nettype none

module switch_port_device_control_tb_top
	import devctl_pkg::*;
;

	// ************************************************************
	// signals and design instance
	// ************************************************************
	typedef struct packed {
		logic [15:0] wr;
		logic [15:0] exp;
	} row_t;

	logic        i_clk                 = 1'h0;
	logic        i_rst_n               = 1'h0;
	logic        i_por_n               = 1'h0;
	logic        i_large_payload_strap = 1'h0;
	logic [7:0]  i_addr                = 8'h00;
	logic [31:0] i_wdata               = 32'h0;
	logic        i_wr                  = 1'h0;
	logic        i_rd                  = 1'h0;
	logic [3:0]  err                   = 4'h0;
	logic        i_aux_pwr_det         = 1'h0;
	logic [31:0] o_rdata;
	wire  [3:0]  msg;
	logic [2:0]  o_max_payload;
	logic [2:0]  o_max_payload_sup;
	logic        o_aux_pwr_en;
	logic [3:0]  seen_msg;
	logic [3:0]  seen_after;
	logic [31:0] seen_rd;
	int          bad_count             = 0;
	int          n_checks              = 0;
	row_t        rows [11]             = '{
		'{16'hFFFF, 16'h042F}, '{16'h0000, 16'h0000}, '{16'h0020, 16'h0020},
		'{16'h0040, 16'h0020}, '{16'h00E0, 16'h0020}, '{16'h0005, 16'h0005},
		'{16'h000A, 16'h000A}, '{16'h0300, 16'h0000}, '{16'h8810, 16'h0000},
		'{16'h7000, 16'h0000}, '{16'h0400, 16'h0400}};

	always #50 i_clk = ~i_clk;

	devctl_top devctl_top_i (
		.i_clk                 (i_clk),
		.i_rst_n               (i_rst_n),
		.i_por_n               (i_por_n),
		.i_large_payload_strap (i_large_payload_strap),
		.i_addr                (i_addr),
		.i_wdata               (i_wdata),
		.i_wr                  (i_wr),
		.i_rd                  (i_rd),
		.o_rdata               (o_rdata),
		.i_err_corr            (err[0]),
		.i_err_nonfatal        (err[1]),
		.i_err_fatal           (err[2]),
		.i_err_unsup           (err[3]),
		.i_aux_pwr_det         (i_aux_pwr_det),
		.o_msg_corr            (msg[0]),
		.o_msg_nonfatal        (msg[1]),
		.o_msg_fatal           (msg[2]),
		.o_msg_unsup           (msg[3]),
		.o_max_payload         (o_max_payload),
		.o_max_payload_sup     (o_max_payload_sup),
		.o_aux_pwr_en          (o_aux_pwr_en)
	);

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'h1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'h0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		i_rd <= 1'h1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'h0;
		#1;
		chk(name, exp, o_rdata);
	endtask

	// write strobe, then read strobe in the very next cycle
	task automatic wr_rd_chk(input string name, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] exp);
		@(posedge i_clk);
		i_wr <= 1'h1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'h0;
		i_rd <= 1'h1;
		@(posedge i_clk);
		i_rd <= 1'h0;
		#1;
		chk(name, exp, o_rdata);
	endtask

	// called right after an edge; error pulse then status read back to back
	task automatic pulse_err(output logic [3:0] m, output logic [3:0] m_after,
			output logic [31:0] r);
		err <= 4'hF;
		@(posedge i_clk);
		err <= 4'h0;
		i_rd <= 1'h1;
		i_addr <= DEV_CTL_ADDR;
		#1;
		m = msg;
		@(posedge i_clk);
		i_rd <= 1'h0;
		#1;
		m_after = msg;
		r = o_rdata;
	endtask

	task automatic do_reset(input logic por, input logic strap, input int n);
		@(posedge i_clk);
		i_rst_n <= 1'h0;
		i_por_n <= ~por;
		i_large_payload_strap <= strap;
		repeat (n) @(posedge i_clk);
		i_rst_n <= 1'h1;
		i_por_n <= 1'h1;
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		do_reset(1'h1, 1'h0, 20);
		rd_chk("ctl_after_reset", DEV_CTL_ADDR, 32'h0);
		@(posedge i_clk);
		#1;
		chk("rdata_idle", 32'h0, o_rdata);
		rd_chk("cap_small", DEV_CAP_ADDR, 32'h00008001);
		chk("sup_small", 32'h1, {29'h0, o_max_payload_sup});
		$display("test reset done");

		for (int k = 0; k < 11; k++) begin
			wr_rd_chk("ctl_row", DEV_CTL_ADDR, {16'h0000, rows[k].wr}, {16'h0000, rows[k].exp});
			chk("payload_row", {29'h0, rows[k].exp[7:5]}, {29'h0, o_max_payload});
			chk("aux_row", {31'h0, rows[k].exp[10]}, {31'h0, o_aux_pwr_en});
		end
		$display("test table done");

		bus_wr(8'hCC, 32'h0000FFFF);
		rd_chk("ctl_after_unmapped", DEV_CTL_ADDR, 32'h00000400);
		rd_chk("unmapped_read", 8'hCC, 32'h0);
		bus_wr(DEV_CAP_ADDR, 32'hFFFFFFFF);
		rd_chk("cap_readonly", DEV_CAP_ADDR, 32'h00008001);
		$display("test refusals done");

		// ordinary reset keeps the aux enable, strap now high
		do_reset(1'h0, 1'h1, 2);
		rd_chk("ctl_sticky", DEV_CTL_ADDR, 32'h00000400);
		chk("aux_sticky", 32'h1, {31'h0, o_aux_pwr_en});
		rd_chk("cap_large", DEV_CAP_ADDR, 32'h00008002);
		chk("sup_large", 32'h2, {29'h0, o_max_payload_sup});
		bus_wr(DEV_CTL_ADDR, 32'h000004E0);
		rd_chk("ctl_clamp_large", DEV_CTL_ADDR, 32'h00000440);
		chk("payload_large", 32'h2, {29'h0, o_max_payload});
		do_reset(1'h1, 1'h1, 2);
		rd_chk("ctl_after_por", DEV_CTL_ADDR, 32'h0);
		chk("aux_after_por", 32'h0, {31'h0, o_aux_pwr_en});
		$display("test sticky done");

		bus_wr(DEV_CTL_ADDR, 32'h00000005);
		pulse_err(seen_msg, seen_after, seen_rd);
		chk("msg_en5", 32'h5, {28'h0, seen_msg});
		chk("msg_one_cycle", 32'h0, {28'h0, seen_after});
		chk("status_en5", 32'h000F0005, seen_rd);
		bus_wr(DEV_CTL_ADDR, 32'h000F000A);
		rd_chk("status_cleared", DEV_CTL_ADDR, 32'h0000000A);
		bus_wr(DEV_CTL_ADDR, 32'h0000000A);
		pulse_err(seen_msg, seen_after, seen_rd);
		chk("msg_enA", 32'hA, {28'h0, seen_msg});
		chk("msg_one_cycle", 32'h0, {28'h0, seen_after});
		chk("status_enA", 32'h000F000A, seen_rd);
		@(posedge i_clk);
		i_aux_pwr_det <= 1'h1;
		rd_chk("status_aux", DEV_CTL_ADDR, 32'h001F000A);
		// clear and new correctable error in one cycle
		@(posedge i_clk);
		i_wr <= 1'h1;
		i_addr <= DEV_CTL_ADDR;
		i_wdata <= 32'h000F000A;
		err <= 4'h1;
		@(posedge i_clk);
		i_wr <= 1'h0;
		err <= 4'h0;
		rd_chk("status_set_wins", DEV_CTL_ADDR, 32'h0011000A);
		$display("test errors done");
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		$display("watchdog expired");
		end_sim();
	end

endmodule

`default_nettype wire

// ---- verilog/devctl_top.sv ----
// per-port device control register bank with error gating
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// RULE1: bit 0 enables correctable error reporting
// RULE2: bit 1 enables non-fatal error reporting
// RULE3: bit 2 enables fatal error reporting
// RULE4: bit 3 enables unsupported request reporting
// RULE5: relaxed ordering bit 4 reads zero
// RULE6: bits 7:5 hold payload size, reset 000b
// RULE7: oversize payload write stores supported maximum
// RULE8: extended tag, phantom bits read zero
// RULE9: bit 10 sticky aux power enable
// RULE10: no snoop bit 11 reads zero
// RULE11: read request size bits fixed 000b
// RULE12: supported payload 001b or 010b by strap
// RULE13: errors logged regardless of reporting enables
// RULE14: reserved bit 15 reads zero
// RULE15: disabled severity sends no error message
module devctl_top
	import devctl_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_por_n,
	input  wire logic        i_large_payload_strap,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic        i_err_corr,
	input  wire logic        i_err_nonfatal,
	input  wire logic        i_err_fatal,
	input  wire logic        i_err_unsup,
	input  wire logic        i_aux_pwr_det,
	output logic             o_msg_corr,
	output logic             o_msg_nonfatal,
	output logic             o_msg_fatal,
	output logic             o_msg_unsup,
	output logic      [2:0]  o_max_payload,
	output logic      [2:0]  o_max_payload_sup,
	output logic             o_aux_pwr_en
);

	// ****************************************
	// declarations
	// ****************************************
	logic [3:0]  err_en_ff;
	logic [2:0]  mps_ff;
	logic [2:0]  mps_sup_ff;
	logic        aux_en_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic        ctl_wr;
	logic        ctl_rd;
	logic        cap_rd;
	logic [2:0]  mps_clamped;
	logic [3:0]  err_det;
	logic [3:0]  err_clr;
	logic [3:0]  err_sts;
	logic [3:0]  err_msg;
	logic [15:0] ctl_word;
	logic [15:0] sts_word;
	logic [31:0] cap_word;

	// ****************************************
	// address decode
	// ****************************************
	assign ctl_wr = i_wr && (i_addr == DEV_CTL_ADDR);
	assign ctl_rd = i_rd && (i_addr == DEV_CTL_ADDR);
	assign cap_rd = i_rd && (i_addr == DEV_CAP_ADDR);

	// ****************************************
	// supported payload limit from strap
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			if (i_large_payload_strap) begin
				mps_sup_ff <= MPS_SUP_LARGE; // RULE12
			end else begin
				mps_sup_ff <= MPS_SUP_SMALL; // RULE12
			end
		end
	end

	// ****************************************
	// error reporting enables
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			err_en_ff <= ERR_EN_RST;
		end else if (ctl_wr) begin
			err_en_ff[0] <= i_wdata[CE_EN_BIT]; // RULE1
			err_en_ff[1] <= i_wdata[NFE_EN_BIT]; // RULE2
			err_en_ff[2] <= i_wdata[FE_EN_BIT]; // RULE3
			err_en_ff[3] <= i_wdata[UR_EN_BIT]; // RULE4
		end
	end

	// ****************************************
	// max payload size with clamp
	// ****************************************
	mps_clamp u_mps_clamp (
		.i_code (i_wdata[MPS_LSB +: 3]),
		.i_sup  (mps_sup_ff),
		.o_code (mps_clamped)
	);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			mps_ff <= MPS_RST; // RULE6
		end else if (ctl_wr) begin
			mps_ff <= mps_clamped; // RULE7
		end
	end

	// ****************************************
	// sticky aux power enable
	// ****************************************
	// only power-on reset clears it; ordinary reset leaves it alone
	always_ff @(posedge i_clk) begin
		if (!i_por_n) begin
			aux_en_ff <= AUX_EN_RST; // RULE9
		end else if (i_rst_n && ctl_wr) begin
			aux_en_ff <= i_wdata[AUX_EN_BIT]; // RULE9
		end
	end

	// ****************************************
	// error logging and messages
	// ****************************************
	assign err_det = {i_err_unsup, i_err_fatal, i_err_nonfatal, i_err_corr};
	assign err_clr = ctl_wr ? i_wdata[STS_LSB +: 4] : 4'h0;

	err_log u_err_log (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_det   (err_det),
		.i_en    (err_en_ff),
		.i_clr   (err_clr),
		.o_sts   (err_sts),
		.o_msg   (err_msg)
	);

	// ****************************************
	// read words
	// ****************************************
	always_comb begin
		ctl_word                 = 16'h0000; // RULE5 RULE8 RULE10 RULE14
		ctl_word[3:0]            = err_en_ff;
		ctl_word[MPS_LSB +: 3]   = mps_ff;
		ctl_word[AUX_EN_BIT]     = aux_en_ff;
		ctl_word[MRRS_LSB +: 3]  = MRRS_VAL; // RULE11
	end

	always_comb begin
		sts_word                          = 16'h0000;
		sts_word[3:0]                     = err_sts;
		sts_word[AUX_DET_BIT - STS_LSB]   = i_aux_pwr_det;
	end

	always_comb begin
		cap_word                     = 32'h0000_0000;
		cap_word[CAP_MPS_LSB +: 3]   = mps_sup_ff;
		cap_word[CAP_RBER_BIT]       = RBER_VAL;
	end

	// ****************************************
	// read data register
	// ****************************************
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (ctl_rd) begin
			nxt_rdata = {sts_word, ctl_word};
		end else if (cap_rd) begin
			nxt_rdata = cap_word;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rdata_ff <= 32'h0000_0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign o_rdata           = rdata_ff;
	assign o_msg_corr        = err_msg[0];
	assign o_msg_nonfatal    = err_msg[1];
	assign o_msg_fatal       = err_msg[2];
	assign o_msg_unsup       = err_msg[3];
	assign o_max_payload     = mps_ff;
	assign o_max_payload_sup = mps_sup_ff;
	assign o_aux_pwr_en      = aux_en_ff;

	// ****************************************
	// checks
	// ****************************************
	ce_enable_a: assert property ( // RULE1
		@(posedge i_clk) disable iff (!i_rst_n)
		ctl_wr |=> (err_en_ff[0] == $past(i_wdata[CE_EN_BIT]))
	) else $error("correctable enable not written");

	nfe_enable_a: assert property ( // RULE2
		@(posedge i_clk) disable iff (!i_rst_n)
		ctl_wr ##1 ctl_rd |=> (o_rdata[NFE_EN_BIT] == $past(i_wdata[NFE_EN_BIT], 2))
	) else $error("non-fatal enable readback wrong");

	fe_enable_a: assert property ( // RULE3
		@(posedge i_clk) disable iff (!i_rst_n)
		(err_en_ff[2] && i_err_fatal) |=> o_msg_fatal
	) else $error("fatal message missing while enabled");

	ur_enable_a: assert property ( // RULE4
		@(posedge i_clk) disable iff (!i_rst_n)
		(ctl_wr && i_wdata[UR_EN_BIT]) ##1 (!ctl_wr && i_err_unsup) |=> o_msg_unsup
	) else $error("unsupported request message missing");

	en_reset_a: assert property ( // RULE1
		@(posedge i_clk)
		!i_rst_n |=> (err_en_ff == ERR_EN_RST) && (mps_ff == MPS_RST)
	) else $error("control fields not reset");

	rlx_zero_a: assert property ( // RULE5
		@(posedge i_clk) disable iff (!i_rst_n)
		ctl_rd |=> !o_rdata[RLX_BIT]
	) else $error("relaxed ordering reads one");

	mps_store_a: assert property ( // RULE6
		@(posedge i_clk) disable iff (!i_rst_n)
		(ctl_wr && (i_wdata[MPS_LSB +: 3] <= mps_sup_ff))
		|=> (o_max_payload == $past(i_wdata[MPS_LSB +: 3]))
	) else $error("payload size not stored");

	mps_clamp_a: assert property ( // RULE7
		@(posedge i_clk) disable iff (!i_rst_n)
		(ctl_wr && (i_wdata[MPS_LSB +: 3] > mps_sup_ff))
		|=> (o_max_payload == o_max_payload_sup)
	) else $error("oversize payload not clamped");

	mps_hold_a: assert property ( // RULE6
		@(posedge i_clk) disable iff (!i_rst_n)
		!ctl_wr |=> $stable(mps_ff)
	) else $error("payload size changed without write");

	etag_phf_a: assert property ( // RULE8
		@(posedge i_clk) disable iff (!i_rst_n)
		ctl_rd |=> (o_rdata[PHF_BIT:ETAG_BIT] == 2'h0)
	) else $error("tag or phantom bit reads one");

	aux_sticky_a: assert property ( // RULE9
		@(posedge i_clk) disable iff (!i_por_n)
		!i_rst_n |=> (o_aux_pwr_en == $past(o_aux_pwr_en))
	) else $error("aux enable lost on ordinary reset");

	aux_por_a: assert property ( // RULE9
		@(posedge i_clk)
		!i_por_n |=> !o_aux_pwr_en
	) else $error("aux enable not cleared at power on");

	snoop_zero_a: assert property ( // RULE10
		@(posedge i_clk) disable iff (!i_rst_n)
		ctl_rd |=> !o_rdata[SNOOP_BIT]
	) else $error("no snoop bit reads one");

	mrrs_fixed_a: assert property ( // RULE11
		@(posedge i_clk) disable iff (!i_rst_n)
		(ctl_wr && i_wdata[MRRS_LSB +: 3] != 3'h0) ##1 ctl_rd
		|=> (o_rdata[MRRS_LSB +: 3] == MRRS_VAL)
	) else $error("read request size not fixed");

	sup_strap_a: assert property ( // RULE12
		@(posedge i_clk) disable iff (!i_por_n)
		!i_rst_n |=> (o_max_payload_sup ==
			($past(i_large_payload_strap) ? MPS_SUP_LARGE : MPS_SUP_SMALL))
	) else $error("supported payload not from strap");

	log_always_a: assert property ( // RULE13
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_err_corr && !err_en_ff[0]) ##1 ctl_rd |=> o_rdata[STS_LSB]
	) else $error("error not logged while disabled");

	rsvd_zero_a: assert property ( // RULE14
		@(posedge i_clk) disable iff (!i_rst_n)
		(ctl_wr && i_wdata[RSVD_BIT]) ##1 ctl_rd |=> !o_rdata[RSVD_BIT]
	) else $error("reserved bit reads one");

	no_msg_a: assert property ( // RULE15
		@(posedge i_clk) disable iff (!i_rst_n)
		o_msg_corr |-> $past(err_en_ff[0] && i_err_corr)
	) else $error("correctable message without cause");

	rd_one_cycle_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		!ctl_rd && !cap_rd |=> (o_rdata == 32'h0000_0000)
	) else $error("read data outside answer cycle");

endmodule

`default_nettype wire

// ---- verilog/err_log.sv ----
// error detected flags and gated error message pulses
`timescale 1ns/1ns
`default_nettype none

module err_log
	import devctl_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic [3:0] i_det,
	input  wire logic [3:0] i_en,
	input  wire logic [3:0] i_clr,
	output logic      [3:0] o_sts,
	output logic      [3:0] o_msg
);

	logic [3:0] sts_ff;
	logic [3:0] nxt_sts;
	logic [3:0] msg_ff;

	// ****************************************
	// detected flags, set wins over clear
	// ****************************************
	always_comb begin
		nxt_sts = (sts_ff & ~i_clr) | i_det; // RULE13
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sts_ff <= STS_RST;
		end else begin
			sts_ff <= nxt_sts;
		end
	end

	// ****************************************
	// message pulses, gated by enables
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			msg_ff <= 4'h0;
		end else begin
			msg_ff <= i_det & i_en; // RULE15
		end
	end

	assign o_sts = sts_ff;
	assign o_msg = msg_ff;

	set_wins_a: assert property ( // RULE13
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_det[0] && i_clr[0]) |=> sts_ff[0]
	) else $error("detected flag lost on clear");

	msg_gate_a: assert property ( // RULE15
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_det[2] && !i_en[2]) |=> !msg_ff[2]
	) else $error("message sent while disabled");

endmodule

`default_nettype wire

// ---- verilog/mps_clamp.sv ----
// clamps a requested payload size code to the supported maximum
`timescale 1ns/1ns
`default_nettype none

module mps_clamp (
	input  wire logic [2:0] i_code,
	input  wire logic [2:0] i_sup,
	output logic      [2:0] o_code
);

	// ****************************************
	// clamp
	// ****************************************
	always_comb begin
		if (i_code > i_sup) begin
			o_code = i_sup;
		end else begin
			o_code = i_code;
		end
	end

endmodule

`default_nettype wire
